// ==== core/eeprom_params.svh ====
// Constants of the serial memory slave: sizes, fields and timing counts
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH
`define EE_MEM_BYTES 1024
`define EE_ADDR_W 10
`define EE_DATA_W 8
`define EE_PAGE_W 4
`define EE_PAGE_BYTES 16
`define EE_ENTRY_W 18
`define EE_BIT_CNT_W 4
`define EE_BYTE_BITS 4'h8
`define EE_TYPE_CODE 4'hB
`define EE_TYPE_MSB 7
`define EE_TYPE_LSB 4
`define EE_CS_BIT 3
`define EE_BLK_MSB 2
`define EE_BLK_LSB 1
`define EE_RW_BIT 0
`define EE_WR_TIME_MS 10
`define EE_CLK_MHZ 250
`define EE_WR_CYCLES (`EE_WR_TIME_MS * 1000 * `EE_CLK_MHZ)
`define EE_WR_CNT_W 22
`endif

// ==== core/eeprom_pkg.sv ====
// Types shared by the serial memory slave
package eeprom_pkg;
`include "eeprom_params.svh"
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_SLV = 3'h1,
		S_ACK = 3'h2,
		S_WORD = 3'h3,
		S_WDAT = 3'h4,
		S_RD = 3'h5,
		S_MACK = 3'h6,
		S_WAIT = 3'h7
	} bus_state_t;
	typedef logic [`EE_WR_CNT_W-1:0] wr_cnt_t;
	typedef logic [`EE_ADDR_W-1:0] mem_addr_t;
	typedef struct packed {
		logic [`EE_MEM_BYTES-1:0][`EE_DATA_W-1:0] mem;
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic [1:0] cs_s;
		logic [1:0] wp_s;
		logic scl_d;
		logic sda_d;
		logic scl_f;
		logic sda_f;
		logic scl_p;
		logic sda_p;
		bus_state_t state;
		bus_state_t ack_next;
		logic [`EE_BIT_CNT_W-1:0] cnt;
		logic [`EE_DATA_W-1:0] sh;
		mem_addr_t addr;
		logic mack;
		logic ack_slave;
		logic sda_oe;
		logic sda_out;
		logic busy;
		wr_cnt_t timer;
	} slave_state_t;
endpackage

// ==== core/serial_eeprom_bus_slave.sv ====
// Page buffer and two-wire serial memory slave with self-timed programming
`timescale 1ns/1ps
`include "eeprom_params.svh"

module page_fifo #(
	parameter int WIDTH = `EE_ENTRY_W,
	parameter int DEPTH = `EE_PAGE_BYTES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] rd;
		logic [PW-1:0] wr;
		logic [PW:0] cnt;
	} fifo_state_t;
	fifo_state_t st;
	fifo_state_t nxt_st;
	logic push;
	logic pop;

	// Handshake flags from the fill level
	assign in_ready = st.cnt != (PW + 1)'(DEPTH);
	assign out_valid = st.cnt != '0;
	assign out_data = st.mem[st.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and level update
	always_comb begin
		nxt_st = st;
		if (push) begin
			nxt_st.mem[st.wr] = in_data;
			nxt_st.wr = st.wr + 1'b1;
		end
		if (pop) begin
			nxt_st.rd = st.rd + 1'b1;
		end
		if (push && !pop) begin
			nxt_st.cnt = st.cnt + 1'b1;
		end else if (pop && !push) begin
			nxt_st.cnt = st.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= nxt_st;
		end
	end
endmodule // page_fifo

// Function
// - Data changes only while clock low
// - Falling data with clock high starts
// - Rising data with clock high stops
// - Receiver acknowledges by holding data low
// - No master acknowledge: release data line
// - Address: type, device field, direction
// - Direction bit one reads, zero writes
// - Top field bit matches chip select
// - Acknowledge address only when idle, matching
// - Protect high blocks all programming
// - Protect low allows reads and writes
// - Self-timed write within ten milliseconds
// - Storage is 1024 bytes
// - Slave only, never drives clock
// - Page write takes sixteen bytes
// - Stop after data starts programming
// - Protected: refuse first data byte
// - Pointer keeps last address plus one
// - Sequential read advances and wraps
module serial_eeprom_bus_slave
	import eeprom_pkg::*;
#(
	parameter logic [3:0] TYPE_CODE = `EE_TYPE_CODE, // Arbitrary value
	parameter int WR_CYCLES = `EE_WR_CYCLES
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Two-wire bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Strap pins
	input wire logic chip_select_pin,
	input wire logic write_protect_pin,
	// Status
	output logic write_busy
);
	import eeprom_pkg::*;

	localparam wr_cnt_t WR_LAST = wr_cnt_t'(WR_CYCLES - 1);
	slave_state_t st;
	slave_state_t nxt_st;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [`EE_ENTRY_W-1:0] fifo_in_data;
	logic fifo_out_valid;
	logic [`EE_ENTRY_W-1:0] fifo_out_data;
	logic addr_hit;

	// Edges and bus conditions from the filtered lines
	assign scl_rise = st.scl_f && !st.scl_p;
	assign scl_fall = !st.scl_f && st.scl_p;
	assign start_ev = st.scl_f && st.scl_p && st.sda_p && !st.sda_f;
	assign stop_ev = st.scl_f && st.scl_p && !st.sda_p && st.sda_f;
	// Type field and chip select bit of the slave byte
	assign addr_hit = st.sh[`EE_TYPE_MSB:`EE_TYPE_LSB] == TYPE_CODE
		&& st.sh[`EE_CS_BIT] == st.cs_s[1];

	// Page buffer between the bus and the programming engine
	page_fifo #(
		.WIDTH(`EE_ENTRY_W),
		.DEPTH(`EE_PAGE_BYTES)
	) u_page (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(st.busy),
		.out_data(fifo_out_data)
	);

	// Loads a byte for sending and drives its first bit
	function automatic slave_state_t load_byte(input slave_state_t s);
		slave_state_t r;
		r = s;
		r.sh = s.mem[s.addr];
		r.sda_oe = !s.mem[s.addr][`EE_DATA_W-1];
		r.addr = s.addr + 1'b1;
		r.state = S_RD;
		r.cnt = '0;
		return r;
	endfunction

	// Next state of the whole slave
	always_comb begin
		nxt_st = st;
		fifo_in_valid = 1'b0;
		fifo_in_data = {st.addr, st.sh};
		// Two-stage synchronisers, then a two-sample agreement filter
		nxt_st.scl_s = {st.scl_s[0], scl_in};
		nxt_st.sda_s = {st.sda_s[0], sda_in};
		nxt_st.cs_s = {st.cs_s[0], chip_select_pin};
		nxt_st.wp_s = {st.wp_s[0], write_protect_pin};
		nxt_st.scl_d = st.scl_s[1];
		nxt_st.sda_d = st.sda_s[1];
		if (st.scl_s[1] == st.scl_d) begin
			nxt_st.scl_f = st.scl_d;
		end
		if (st.sda_s[1] == st.sda_d) begin
			nxt_st.sda_f = st.sda_d;
		end
		nxt_st.scl_p = st.scl_f;
		nxt_st.sda_p = st.sda_f;
		// Self-timed programming drains the page into storage
		if (st.busy) begin
			if (fifo_out_valid) begin
				nxt_st.mem[fifo_out_data[`EE_ENTRY_W-1:`EE_DATA_W]] =
					fifo_out_data[`EE_DATA_W-1:0];
			end
			if (st.timer == WR_LAST) begin
				nxt_st.busy = 1'b0;
			end else begin
				nxt_st.timer = st.timer + 1'b1;
			end
		end
		if (start_ev) begin
			nxt_st.state = S_SLV;
			nxt_st.cnt = '0;
			nxt_st.sda_oe = 1'b0;
		end else if (stop_ev) begin
			nxt_st.state = S_IDLE;
			nxt_st.sda_oe = 1'b0;
			if (fifo_out_valid && !st.busy) begin
				nxt_st.busy = 1'b1;
				nxt_st.timer = '0;
			end
		end else if (scl_rise) begin
			case (st.state)
				S_SLV, S_WORD, S_WDAT: begin
					if (st.cnt != `EE_BYTE_BITS) begin
						nxt_st.sh = {st.sh[`EE_DATA_W-2:0], st.sda_f};
						nxt_st.cnt = st.cnt + 1'b1;
					end
				end
				S_RD: begin
					nxt_st.cnt = st.cnt + 1'b1;
				end
				S_MACK: begin
					nxt_st.mack = !st.sda_f;
				end
				default: begin
					nxt_st.cnt = st.cnt;
				end
			endcase
		end else if (scl_fall) begin
			case (st.state)
				S_SLV: begin
					if (st.cnt == `EE_BYTE_BITS) begin
						nxt_st.cnt = '0;
						if (addr_hit && !st.busy) begin
							nxt_st.state = S_ACK;
							nxt_st.sda_oe = 1'b1;
							nxt_st.ack_slave = 1'b1;
							nxt_st.addr[`EE_ADDR_W-1:`EE_DATA_W] =
								st.sh[`EE_BLK_MSB:`EE_BLK_LSB];
							nxt_st.ack_next = st.sh[`EE_RW_BIT] ? S_RD : S_WORD;
						end else begin
							nxt_st.state = S_WAIT;
						end
					end
				end
				S_WORD: begin
					if (st.cnt == `EE_BYTE_BITS) begin
						nxt_st.cnt = '0;
						nxt_st.addr[`EE_DATA_W-1:0] = st.sh;
						nxt_st.state = S_ACK;
						nxt_st.sda_oe = 1'b1;
						nxt_st.ack_slave = 1'b0;
						nxt_st.ack_next = S_WDAT;
					end
				end
				S_WDAT: begin
					if (st.cnt == `EE_BYTE_BITS) begin
						nxt_st.cnt = '0;
						if (!st.wp_s[1] && fifo_in_ready) begin
							fifo_in_valid = 1'b1;
							nxt_st.addr[`EE_PAGE_W-1:0] = st.addr[`EE_PAGE_W-1:0] + 1'b1;
							nxt_st.state = S_ACK;
							nxt_st.sda_oe = 1'b1;
							nxt_st.ack_slave = 1'b0;
							nxt_st.ack_next = S_WDAT;
						end else begin
							nxt_st.state = S_WAIT;
						end
					end
				end
				S_ACK: begin
					nxt_st.sda_oe = 1'b0;
					nxt_st.cnt = '0;
					nxt_st.state = st.ack_next;
					if (st.ack_next == S_RD) begin
						nxt_st = load_byte(nxt_st);
					end
				end
				S_RD: begin
					if (st.cnt == `EE_BYTE_BITS) begin
						nxt_st.sda_oe = 1'b0;
						nxt_st.mack = 1'b0;
						nxt_st.state = S_MACK;
					end else begin
						nxt_st.sh = {st.sh[`EE_DATA_W-2:0], 1'b0};
						nxt_st.sda_oe = !st.sh[`EE_DATA_W-2];
					end
				end
				S_MACK: begin
					if (st.mack) begin
						nxt_st = load_byte(nxt_st);
					end else begin
						nxt_st.state = S_WAIT;
						nxt_st.sda_oe = 1'b0;
					end
				end
				default: begin
					nxt_st.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= nxt_st;
		end
	end

	// Open-drain data pin; the clock pin is input only
	assign sda_out = st.sda_out;
	assign sda_oe = st.sda_oe;
	assign write_busy = st.busy;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_drive_clock_low: assert property ($rose(st.sda_oe) |-> !$past(st.scl_f))
		else $error("data line driven while clock high");
	a_start_entry: assert property (start_ev |=> st.state == S_SLV && st.cnt == '0)
		else $error("start not taken");
	a_stop_release: assert property (stop_ev |=> st.state == S_IDLE && !st.sda_oe)
		else $error("stop not taken");
	// Acknowledge stays pulled low until the clock falls after the ninth pulse
	a_ack_hold: assert property (st.state == S_ACK && !scl_fall && !start_ev && !stop_ev
		|=> st.state == S_ACK && st.sda_oe)
		else $error("acknowledge dropped early");
	a_busy_no_ack: assert property (st.busy |-> !(st.state == S_ACK && st.ack_slave))
		else $error("address acknowledged while programming");
	a_wp_no_push: assert property (fifo_in_valid |-> !st.wp_s[1])
		else $error("data accepted while protected");
	a_prog_start: assert property (stop_ev && fifo_out_valid && !st.busy |=> st.busy)
		else $error("programming not started at stop");
	a_prog_bound: assert property (st.busy |-> st.timer <= WR_LAST)
		else $error("write timer out of range");
	a_prog_end: assert property (st.busy && st.timer == WR_LAST |=> !st.busy)
		else $error("programming did not end on time");
	a_dir_read: assert property (st.state == S_ACK && st.ack_slave && st.ack_next == S_RD
		|-> st.sh[`EE_RW_BIT])
		else $error("direction bit misread");
	a_seq_advance: assert property (st.state == S_MACK && scl_fall && st.mack && !start_ev
		&& !stop_ev |=> st.addr == $past(st.addr) + 1'b1 && st.state == S_RD)
		else $error("sequential read did not advance");
	a_nack_release: assert property (st.state == S_MACK && scl_fall && !st.mack
		&& !start_ev && !stop_ev |=> !st.sda_oe && st.state == S_WAIT)
		else $error("line not released after no acknowledge");

	c_start_seen: cover property (start_ev);
	c_prog_run: cover property ($rose(st.busy));
	c_read_byte: cover property (st.state == S_MACK && st.mack);
	c_wp_refuse: cover property (st.state == S_WDAT && scl_fall && st.wp_s[1]);
endmodule // serial_eeprom_bus_slave

// ==== testbench/master.sv ====
// Two-wire bus master model that clocks bytes in and out of the slave
`timescale 1ns/1ps
module master (
	// Bus lines
	output logic scl,
	output logic sda_drv,
	input wire logic sda
);
	localparam realtime Q = 24ns;
	// Idle bus: clock stands high, data released
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// One bit: data moves while clock low, sampled mid high
	task automatic bit_cyc(input logic b, output logic s);
		sda_drv = b;
		#Q;
		scl = 1'b1;
		#Q;
		s = sda;
		#Q;
		scl = 1'b0;
		#Q;
	endtask
	// Data falls while clock high
	task automatic start();
		sda_drv = 1'b1;
		#Q;
		scl = 1'b1;
		#Q;
		sda_drv = 1'b0;
		#Q;
		scl = 1'b0;
		#Q;
	endtask
	// Data rises while clock high
	task automatic stop();
		sda_drv = 1'b0;
		#Q;
		scl = 1'b1;
		#Q;
		sda_drv = 1'b1;
		#(2 * Q);
	endtask
	// Byte out MSB first, ninth clock reads the acknowledge
	task automatic wr(input logic [7:0] b, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(b[i], s);
		end
		bit_cyc(1'b1, s);
		a = ~s;
	endtask
	// Byte in, then acknowledge or withhold it
	task automatic rd(output logic [7:0] b, input logic a);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_cyc(1'b1, b[i]);
		end
		bit_cyc(~a, s);
	endtask
endmodule // master

// ==== testbench/serial_eeprom_bus_slave_tb.sv ====
// Self-checking bench for the two-wire serial memory slave
`timescale 1ns/1ps
`include "eeprom_params.svh"
module serial_eeprom_bus_slave_tb;
	localparam int WR_CYC = 2000;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic chip_select_pin = 1'b1;
	logic write_protect_pin = 1'b0;
	logic scl, sda_drv, sda_out, sda_oe, write_busy, a;
	logic [7:0] b;
	wire logic sda;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int busy_len = 0;
	// Open-drain data wire with pull-up
	assign sda = sda_drv & ~sda_oe;
	always #2 sys_clk = ~sys_clk;
	master i_master (.scl(scl), .sda_drv(sda_drv), .sda(sda));
	serial_eeprom_bus_slave #(.WR_CYCLES(WR_CYC)) i_serial_eeprom_bus_slave (
		.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .chip_select_pin(chip_select_pin),
		.write_protect_pin(write_protect_pin), .write_busy(write_busy));
	// Cycle ceiling and busy-length count
	always @(posedge sys_clk) begin
		cyc++;
		busy_len += (write_busy === 1'b1);
		if (cyc == 80000) begin
			errors++;
			stop_test();
		end
	end
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	function automatic logic [7:0] sa(input logic [1:0] blk, input logic rw);
		return {`EE_TYPE_CODE, chip_select_pin, blk, rw};
	endfunction
	task automatic sel(input logic [7:0] s);
		i_master.start();
		i_master.wr(s, a);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < WR_CYC + 99; i++) begin
			@(negedge sys_clk);
			if (write_busy === 1'b0) break;
		end
	endtask
	// Two-byte write, no ack to polling while busy
	task automatic t_write();
		busy_len = 0;
		sel(sa(2'h0, 1'b0));
		check("slave ack", 1, a);
		check("sda out", 0, sda_out);
		i_master.wr(8'h00, a);
		i_master.wr(8'h5A, a);
		check("data ack", 1, a);
		i_master.wr(8'hC3, a);
		i_master.stop();
		check("busy", 1, write_busy);
		sel(sa(2'h0, 1'b0));
		check("poll ack", 0, a);
		i_master.stop();
		wait_idle();
		check("busy len", 1, busy_len >= WR_CYC - 1 && busy_len <= WR_CYC + 1);
	endtask
	// Read at the top address rolls over, then current-address read
	task automatic t_read();
		sel(sa(2'h3, 1'b0));
		i_master.wr(8'hFF, a);
		sel(sa(2'h3, 1'b1));
		check("read ack", 1, a);
		i_master.rd(b, 1'b1);
		check("byte 3FF", 8'h00, b);
		i_master.rd(b, 1'b0);
		check("byte 000", 8'h5A, b);
		i_master.stop();
		check("released", 0, sda_oe);
		sel(sa(2'h0, 1'b1));
		i_master.rd(b, 1'b0);
		check("current", 8'hC3, b);
		i_master.stop();
	endtask
	// Chip select and type code must match
	task automatic t_select();
		sel({`EE_TYPE_CODE, ~chip_select_pin, 3'h0});
		check("bad select", 0, a);
		i_master.stop();
		sel({~`EE_TYPE_CODE, chip_select_pin, 3'h0});
		check("bad type", 0, a);
		i_master.stop();
		@(posedge sys_clk) chip_select_pin <= 1'b0;
		#1;
		sel({`EE_TYPE_CODE, 4'h4});
		check("select low", 1, a);
		i_master.stop();
		@(posedge sys_clk) chip_select_pin <= 1'b1;
		#1;
	endtask
	// Protected memory takes addresses, refuses data, still reads
	task automatic t_protect();
		@(posedge sys_clk) write_protect_pin <= 1'b1;
		#1;
		sel(sa(2'h0, 1'b0));
		check("wp slave", 1, a);
		i_master.wr(8'h00, a);
		check("wp word", 1, a);
		i_master.wr(8'hFF, a);
		check("wp data", 0, a);
		i_master.stop();
		check("wp busy", 0, write_busy);
		sel(sa(2'h0, 1'b1));
		i_master.rd(b, 1'b0);
		check("wp kept", 8'h5A, b);
		i_master.stop();
		@(posedge sys_clk) write_protect_pin <= 1'b0;
		#1;
	endtask
	// Sixteen bytes fill the page; the seventeenth is refused
	task automatic t_page();
		sel(sa(2'h1, 1'b0));
		i_master.wr(8'h10, a);
		for (int i = 0; i < 17; i++) begin
			i_master.wr(8'h20 + i[7:0], a);
			check("page ack", i < 16, a);
		end
		i_master.stop();
		wait_idle();
		sel(sa(2'h1, 1'b0));
		i_master.wr(8'h10, a);
		sel(sa(2'h1, 1'b1));
		for (int i = 0; i < 17; i++) begin
			i_master.rd(b, i < 16);
			check("page byte", i < 16 ? 8'h20 + i[7:0] : 8'h00, b);
		end
		i_master.stop();
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge sys_clk);
		#1;
		t_write();
		t_read();
		t_select();
		t_protect();
		t_page();
		stop_test();
	end
endmodule // serial_eeprom_bus_slave_tb
